// [core/jtag_pkg.sv]
// Shared constants and types for the test access port and its configuration path.
// Assumes one test clock domain and one system clock domain.
`default_nettype none

package jtag_pkg;

	localparam int unsigned IR_LEN    = 6;
	localparam int unsigned ID_W      = 32;
	localparam int unsigned CFG_W     = 32;
	localparam int unsigned MODE_W    = 3;
	localparam int unsigned SYNC_LEN  = 3;

	localparam logic [IR_LEN-1:0] INS_EXTEST  = 6'h26;
	localparam logic [IR_LEN-1:0] INS_SAMPLE  = 6'h01;
	localparam logic [IR_LEN-1:0] INS_IDCODE  = 6'h09;
	localparam logic [IR_LEN-1:0] INS_CFG_IN  = 6'h05;
	localparam logic [IR_LEN-1:0] INS_CFG_OUT = 6'h04;
	localparam logic [IR_LEN-1:0] INS_BYPASS  = 6'h3f;
	localparam logic [IR_LEN-1:0] IR_CAPTURE  = 6'h01;

	localparam logic [MODE_W-1:0] MODE_JTAG   = 3'h5;

	// Identification value is arbitrary; bit 0 is one as the standard asks.
	localparam logic [ID_W-1:0]   ID_DEFAULT  = 32'h0a5c_3001;

	typedef enum logic [3:0] {
		TAP_RESET    = 4'h0,
		TAP_IDLE     = 4'h1,
		TAP_SEL_DR   = 4'h3,
		TAP_CAP_DR   = 4'h2,
		TAP_SHIFT_DR = 4'h6,
		TAP_EX1_DR   = 4'h7,
		TAP_PAUSE_DR = 4'h5,
		TAP_EX2_DR   = 4'h4,
		TAP_UPD_DR   = 4'hc,
		TAP_SEL_IR   = 4'hd,
		TAP_CAP_IR   = 4'hf,
		TAP_SHIFT_IR = 4'he,
		TAP_EX1_IR   = 4'ha,
		TAP_PAUSE_IR = 4'hb,
		TAP_EX2_IR   = 4'h9,
		TAP_UPD_IR   = 4'h8
	} tap_e;

	typedef enum logic [1:0] {
		DR_BYP = 2'h0,
		DR_ID  = 2'h1,
		DR_BSR = 2'h2,
		DR_CFG = 2'h3
	} dr_e;

endpackage : jtag_pkg

`default_nettype wire

// [core/level_sync.sv]
// Three-stage synchroniser with agreement filter for levels from another domain.
// Assumes each bit is a level that holds long enough for two stages to agree.
`default_nettype none

module level_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         en,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] q_d;

	if (W < 1) begin : g_width_check
		$error("level_sync needs at least one bit.");
	end

	// A bit takes the new value only when the second and third stages agree.
	always_comb begin
		for (int i = 0; i < W; i++) begin
			q_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : q[i];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q    <= '0;
		end else if (en) begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			q    <= q_d;
		end
	end

endmodule : level_sync

`default_nettype wire

// [core/jtag_tap_config_access.sv]
// Test access port with bypass, identification, boundary and configuration registers.
// Assumes TCK comes from the external controller and MCLK is the device's system clock.
`default_nettype none

module jtag_tap_config_access #(
	parameter int unsigned              BSR_LEN = 8,
	parameter logic [jtag_pkg::ID_W-1:0] ID_VALUE = jtag_pkg::ID_DEFAULT
) (
	input  wire logic                        MCLK,
	input  wire logic                        RST_N,
	input  wire logic                        CE,
	input  wire logic                        TCK,
	input  wire logic                        TMS,
	input  wire logic                        TDI,
	output logic                             TDO_O,
	output logic                             TDO_OE,
	input  wire logic [jtag_pkg::MODE_W-1:0] MODE_PINS,
	input  wire logic [BSR_LEN-1:0]          BSR_PI,
	output logic      [BSR_LEN-1:0]          BSR_PO,
	output logic      [jtag_pkg::CFG_W-1:0]  CFG_WDATA,
	output logic                             CFG_WVALID,
	output logic                             CFG_RREQ,
	input  wire logic                        CFG_RVALID,
	input  wire logic [jtag_pkg::CFG_W-1:0]  CFG_RDATA,
	output logic                             JTAG_EXCL,
	output logic                             JTAG_CFG_PRI,
	output logic                             OTHER_CFG_EN
);

	localparam int unsigned IRL = jtag_pkg::IR_LEN;
	localparam int unsigned CW  = jtag_pkg::CFG_W;
	if (BSR_LEN < 2) begin : g_bsr_check
		$error("Boundary register needs at least two cells.");
	end

	// Instruction decode to the data register it selects; unknown codes select bypass.
	function automatic jtag_pkg::dr_e dr_sel(input logic [IRL-1:0] ins);
		jtag_pkg::dr_e r;
		r = jtag_pkg::DR_BYP;
		if (ins == jtag_pkg::INS_IDCODE) begin
			r = jtag_pkg::DR_ID;
		end else if (ins == jtag_pkg::INS_SAMPLE || ins == jtag_pkg::INS_EXTEST) begin
			r = jtag_pkg::DR_BSR;
		end else if (ins == jtag_pkg::INS_CFG_IN || ins == jtag_pkg::INS_CFG_OUT) begin
			r = jtag_pkg::DR_CFG;
		end
		return r;
	endfunction : dr_sel

	// Test clock domain state.
	jtag_pkg::tap_e       tap_q,      tap_d;
	logic [IRL-1:0]       ir_sh_q,    ir_sh_d;
	logic [IRL-1:0]       ir_q,       ir_d;
	logic                 byp_q,      byp_d;
	logic [31:0]          id_sh_q,    id_sh_d;
	logic [BSR_LEN-1:0]   bsr_sh_q,   bsr_sh_d;
	logic [BSR_LEN-1:0]   bsr_po_q,   bsr_po_d;
	logic [CW-1:0]        cfg_sh_q,   cfg_sh_d;
	logic [CW-1:0]        cfg_hold_q, cfg_hold_d;
	logic [CW-1:0]        rb_q,       rb_d;
	logic                 wr_tgl_q,   wr_tgl_d;
	logic                 rd_req_q,   rd_req_d;
	logic                 ack_seen_q, ack_seen_d;
	logic                 cfg_act_q,  cfg_act_d;
	logic                 ack_sync;
	jtag_pkg::dr_e        sel;
	// System clock domain state.
	logic [2:0]           tck_side;
	logic [jtag_pkg::MODE_W-1:0] mode_sync;
	logic                 wr_seen_q,  wr_seen_d;
	logic                 rd_seen_q,  rd_seen_d;
	logic [CW-1:0]        wdata_q,    wdata_d;
	logic                 wvalid_q,   wvalid_d;
	logic                 rpend_q,    rpend_d;
	logic [CW-1:0]        rd_word_q,  rd_word_d;
	logic                 rd_ack_q,   rd_ack_d;
	logic                 excl_q,     excl_d;
	logic                 pri_q,      pri_d;
	// Falling-edge output state.
	logic                 tdo_q,      tdo_d;
	logic                 tdo_oe_q,   tdo_oe_d;
	assign sel = dr_sel(ir_q);
	always_comb begin
		tap_d      = tap_q;
		ir_sh_d    = ir_sh_q;
		ir_d       = ir_q;
		byp_d      = byp_q;
		id_sh_d    = id_sh_q;
		bsr_sh_d   = bsr_sh_q;
		bsr_po_d   = bsr_po_q;
		cfg_sh_d   = cfg_sh_q;
		cfg_hold_d = cfg_hold_q;
		rb_d       = rb_q;
		wr_tgl_d   = wr_tgl_q;
		rd_req_d   = rd_req_q;
		ack_seen_d = ack_seen_q;
		cfg_act_d  = cfg_act_q;
		// State walk follows the standard diagram; TMS high five times reaches reset.
		unique case (tap_q)
			jtag_pkg::TAP_RESET:    tap_d = TMS ? jtag_pkg::TAP_RESET  : jtag_pkg::TAP_IDLE;
			jtag_pkg::TAP_IDLE:     tap_d = TMS ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
			jtag_pkg::TAP_SEL_DR:   tap_d = TMS ? jtag_pkg::TAP_SEL_IR : jtag_pkg::TAP_CAP_DR;
			jtag_pkg::TAP_CAP_DR:   tap_d = TMS ? jtag_pkg::TAP_EX1_DR : jtag_pkg::TAP_SHIFT_DR;
			jtag_pkg::TAP_SHIFT_DR: tap_d = TMS ? jtag_pkg::TAP_EX1_DR : jtag_pkg::TAP_SHIFT_DR;
			jtag_pkg::TAP_EX1_DR:   tap_d = TMS ? jtag_pkg::TAP_UPD_DR : jtag_pkg::TAP_PAUSE_DR;
			jtag_pkg::TAP_PAUSE_DR: tap_d = TMS ? jtag_pkg::TAP_EX2_DR : jtag_pkg::TAP_PAUSE_DR;
			jtag_pkg::TAP_EX2_DR:   tap_d = TMS ? jtag_pkg::TAP_UPD_DR : jtag_pkg::TAP_SHIFT_DR;
			jtag_pkg::TAP_UPD_DR:   tap_d = TMS ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
			jtag_pkg::TAP_SEL_IR:   tap_d = TMS ? jtag_pkg::TAP_RESET  : jtag_pkg::TAP_CAP_IR;
			jtag_pkg::TAP_CAP_IR:   tap_d = TMS ? jtag_pkg::TAP_EX1_IR : jtag_pkg::TAP_SHIFT_IR;
			jtag_pkg::TAP_SHIFT_IR: tap_d = TMS ? jtag_pkg::TAP_EX1_IR : jtag_pkg::TAP_SHIFT_IR;
			jtag_pkg::TAP_EX1_IR:   tap_d = TMS ? jtag_pkg::TAP_UPD_IR : jtag_pkg::TAP_PAUSE_IR;
			jtag_pkg::TAP_PAUSE_IR: tap_d = TMS ? jtag_pkg::TAP_EX2_IR : jtag_pkg::TAP_PAUSE_IR;
			jtag_pkg::TAP_EX2_IR:   tap_d = TMS ? jtag_pkg::TAP_UPD_IR : jtag_pkg::TAP_SHIFT_IR;
			jtag_pkg::TAP_UPD_IR:   tap_d = TMS ? jtag_pkg::TAP_SEL_DR : jtag_pkg::TAP_IDLE;
		endcase
		// Register actions of the current state.
		unique case (tap_q)
			jtag_pkg::TAP_RESET: begin
				ir_d = jtag_pkg::INS_IDCODE;
				cfg_act_d = 1'b0;
			end
			jtag_pkg::TAP_CAP_IR: begin
				ir_sh_d = jtag_pkg::IR_CAPTURE;
			end
			jtag_pkg::TAP_SHIFT_IR: begin
				ir_sh_d = {TDI, ir_sh_q[IRL-1:1]};
			end
			jtag_pkg::TAP_UPD_IR: begin
				ir_d = ir_sh_q;
				cfg_act_d = (ir_sh_q == jtag_pkg::INS_CFG_IN);
				if (ir_sh_q == jtag_pkg::INS_CFG_OUT) begin
					rd_req_d = ~rd_req_q;
				end
			end
			jtag_pkg::TAP_CAP_DR: begin
				unique case (sel)
					jtag_pkg::DR_BYP: byp_d    = 1'b0;
					jtag_pkg::DR_ID:  id_sh_d  = ID_VALUE;
					jtag_pkg::DR_BSR: bsr_sh_d = BSR_PI;
					jtag_pkg::DR_CFG: cfg_sh_d = (ir_q == jtag_pkg::INS_CFG_OUT) ? rb_q : '0;
				endcase
			end
			jtag_pkg::TAP_SHIFT_DR: begin
				unique case (sel)
					jtag_pkg::DR_BYP: byp_d    = TDI;
					jtag_pkg::DR_ID:  id_sh_d  = {TDI, id_sh_q[31:1]};
					jtag_pkg::DR_BSR: bsr_sh_d = {TDI, bsr_sh_q[BSR_LEN-1:1]};
					jtag_pkg::DR_CFG: cfg_sh_d = {TDI, cfg_sh_q[CW-1:1]};
				endcase
			end
			jtag_pkg::TAP_UPD_DR: begin
				if (ir_q == jtag_pkg::INS_EXTEST) begin
					bsr_po_d = bsr_sh_q;
				end
				if (ir_q == jtag_pkg::INS_CFG_IN) begin
					cfg_hold_d = cfg_sh_q;
					wr_tgl_d   = ~wr_tgl_q;
				end
				if (ir_q == jtag_pkg::INS_CFG_OUT) begin
					rd_req_d = ~rd_req_q;
				end
			end
			default: begin
			end
		endcase
		// Readback word is stable in the system domain once its acknowledge toggles.
		if (ack_sync != ack_seen_q) begin
			ack_seen_d = ack_sync;
			rb_d       = rd_word_q;
		end
	end

	// No test reset pin: only power-on reset or the TMS sequence reset the controller.
	always_ff @(posedge TCK or negedge RST_N) begin
		if (!RST_N) begin
			tap_q      <= jtag_pkg::TAP_RESET;
			ir_sh_q    <= '0;
			ir_q       <= jtag_pkg::INS_IDCODE;
			byp_q      <= 1'b0;
			id_sh_q    <= '0;
			bsr_sh_q   <= '0;
			bsr_po_q   <= '0;
			cfg_sh_q   <= '0;
			cfg_hold_q <= '0;
			rb_q       <= '0;
			wr_tgl_q   <= 1'b0;
			rd_req_q   <= 1'b0;
			ack_seen_q <= 1'b0;
			cfg_act_q  <= 1'b0;
		end else begin
			tap_q      <= tap_d;
			ir_sh_q    <= ir_sh_d;
			ir_q       <= ir_d;
			byp_q      <= byp_d;
			id_sh_q    <= id_sh_d;
			bsr_sh_q   <= bsr_sh_d;
			bsr_po_q   <= bsr_po_d;
			cfg_sh_q   <= cfg_sh_d;
			cfg_hold_q <= cfg_hold_d;
			rb_q       <= rb_d;
			wr_tgl_q   <= wr_tgl_d;
			rd_req_q   <= rd_req_d;
			ack_seen_q <= ack_seen_d;
			cfg_act_q  <= cfg_act_d;
		end
	end

	// Output stage follows the serial end of the selected register.
	always_comb begin
		tdo_d    = 1'b1;
		tdo_oe_d = 1'b0;
		if (tap_q == jtag_pkg::TAP_SHIFT_IR) begin
			tdo_d    = ir_sh_q[0];
			tdo_oe_d = 1'b1;
		end else if (tap_q == jtag_pkg::TAP_SHIFT_DR) begin
			tdo_oe_d = 1'b1;
			unique case (sel)
				jtag_pkg::DR_BYP: tdo_d = byp_q;
				jtag_pkg::DR_ID:  tdo_d = id_sh_q[0];
				jtag_pkg::DR_BSR: tdo_d = bsr_sh_q[0];
				jtag_pkg::DR_CFG: tdo_d = cfg_sh_q[0];
			endcase
		end
	end
	always_ff @(negedge TCK or negedge RST_N) begin
		if (!RST_N) begin
			tdo_q    <= 1'b1;
			tdo_oe_q <= 1'b0;
		end else begin
			tdo_q    <= tdo_d;
			tdo_oe_q <= tdo_oe_d;
		end
	end

	// Released output shows high, matching the pull-up on the wire.
	assign TDO_O  = tdo_oe_q ? tdo_q : 1'b1;
	assign TDO_OE = tdo_oe_q;
	assign BSR_PO = bsr_po_q;

	level_sync #(.W (1)) u_ack_sync (
		.clk   (TCK),
		.rst_n (RST_N),
		.en    (1'b1),
		.d     (rd_ack_q),
		.q     (ack_sync)
	);
	level_sync #(.W (3)) u_tck_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.en    (CE),
		.d     ({cfg_act_q, rd_req_q, wr_tgl_q}),
		.q     (tck_side)
	);
	level_sync #(.W (jtag_pkg::MODE_W)) u_mode_sync (
		.clk   (MCLK),
		.rst_n (RST_N),
		.en    (CE),
		.d     (MODE_PINS),
		.q     (mode_sync)
	);

	always_comb begin
		wr_seen_d = wr_seen_q;
		rd_seen_d = rd_seen_q;
		wdata_d   = wdata_q;
		wvalid_d  = 1'b0;
		rpend_d   = rpend_q;
		rd_word_d = rd_word_q;
		rd_ack_d  = rd_ack_q;
		excl_d    = (mode_sync == jtag_pkg::MODE_JTAG);
		pri_d     = (mode_sync == jtag_pkg::MODE_JTAG) || tck_side[2];
		if (tck_side[0] != wr_seen_q) begin
			wr_seen_d = tck_side[0];
			wdata_d   = cfg_hold_q;
			wvalid_d  = 1'b1;
		end
		if (tck_side[1] != rd_seen_q) begin
			rd_seen_d = tck_side[1];
			rpend_d   = 1'b1;
		end else if (rpend_q && CFG_RVALID) begin
			rpend_d   = 1'b0;
			rd_word_d = CFG_RDATA;
			rd_ack_d  = ~rd_ack_q;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_seen_q <= 1'b0;
			rd_seen_q <= 1'b0;
			wdata_q   <= '0;
			wvalid_q  <= 1'b0;
			rpend_q   <= 1'b0;
			rd_word_q <= '0;
			rd_ack_q  <= 1'b0;
			excl_q    <= 1'b0;
			pri_q     <= 1'b0;
		end else if (CE) begin
			wr_seen_q <= wr_seen_d;
			rd_seen_q <= rd_seen_d;
			wdata_q   <= wdata_d;
			wvalid_q  <= wvalid_d;
			rpend_q   <= rpend_d;
			rd_word_q <= rd_word_d;
			rd_ack_q  <= rd_ack_d;
			excl_q    <= excl_d;
			pri_q     <= pri_d;
		end
	end
	assign CFG_WDATA    = wdata_q;
	assign CFG_WVALID   = wvalid_q;
	assign CFG_RREQ     = rpend_q;
	assign JTAG_EXCL    = excl_q;
	assign JTAG_CFG_PRI = pri_q;
	assign OTHER_CFG_EN = ~pri_q;

endmodule : jtag_tap_config_access

`default_nettype wire

// [test/jtag_tap_properties.sv]
// Concurrent checks on the test port pins and the system-side handshakes.
// Assumes it is bound to the test port top module and sees only its ports.
`default_nettype none

module jtag_tap_checker (
	input wire logic        MCLK,
	input wire logic        RST_N,
	input wire logic        CE,
	input wire logic        TCK,
	input wire logic        TDO_O,
	input wire logic        TDO_OE,
	input wire logic [2:0]  MODE_PINS,
	input wire logic [31:0] CFG_WDATA,
	input wire logic        CFG_WVALID,
	input wire logic        CFG_RREQ,
	input wire logic        CFG_RVALID,
	input wire logic        JTAG_EXCL,
	input wire logic        JTAG_CFG_PRI
);
	timeunit 1ns;
	timeprecision 1ns;

	logic tdo_q;
	logic oe_q;

	always_ff @(posedge TCK or negedge RST_N) begin
		if (!RST_N) begin
			tdo_q <= 1'b1;
			oe_q  <= 1'b0;
		end else begin
			tdo_q <= TDO_O;
			oe_q  <= TDO_OE;
		end
	end

	property p_tdo_fall;
		@(negedge TCK) disable iff (!RST_N) TDO_O == tdo_q && TDO_OE == oe_q;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall) else $error("TDO moved on rising TCK");
	property p_tdo_idle;
		@(posedge MCLK) disable iff (!RST_N) !TDO_OE |-> TDO_O;
	endproperty
	a_tdo_idle: assert property (p_tdo_idle) else $error("idle TDO not high");
	property p_wv_pulse;
		@(posedge MCLK) disable iff (!RST_N) CFG_WVALID && CE |=> !CFG_WVALID;
	endproperty
	a_wv_pulse: assert property (p_wv_pulse) else $error("write valid too long");
	property p_wd_hold;
		@(posedge MCLK) disable iff (!RST_N) $changed(CFG_WDATA) |-> CFG_WVALID;
	endproperty
	a_wd_hold: assert property (p_wd_hold) else $error("write word moved alone");
	property p_rreq_hold;
		@(posedge MCLK) disable iff (!RST_N) CFG_RREQ && !CFG_RVALID && CE |=> CFG_RREQ;
	endproperty
	a_rreq_hold: assert property (p_rreq_hold) else $error("read request dropped");
	property p_rreq_drop;
		@(posedge MCLK) disable iff (!RST_N) CFG_RREQ && CFG_RVALID && CE |=> !CFG_RREQ;
	endproperty
	a_rreq_drop: assert property (p_rreq_drop) else $error("read request kept");
	property p_excl_on;
		@(posedge MCLK) disable iff (!RST_N)
			(MODE_PINS == jtag_pkg::MODE_JTAG && CE) [*8] |-> JTAG_EXCL;
	endproperty
	a_excl_on: assert property (p_excl_on) else $error("exclusive mode missing");
	property p_pri;
		@(posedge MCLK) disable iff (!RST_N) JTAG_EXCL && $past(JTAG_EXCL) |-> JTAG_CFG_PRI;
	endproperty
	a_pri: assert property (p_pri) else $error("test port lacks priority");

	c_wv: cover property (@(posedge MCLK) CFG_WVALID);
	c_rd: cover property (@(posedge MCLK) CFG_RREQ && CFG_RVALID);
	c_oe: cover property (@(negedge TCK) TDO_OE);
endmodule : jtag_tap_checker

bind jtag_tap_config_access jtag_tap_checker jtag_tap_checker_inst (
	.MCLK(MCLK), .RST_N(RST_N), .CE(CE), .TCK(TCK), .TDO_O(TDO_O), .TDO_OE(TDO_OE),
	.MODE_PINS(MODE_PINS), .CFG_WDATA(CFG_WDATA), .CFG_WVALID(CFG_WVALID),
	.CFG_RREQ(CFG_RREQ), .CFG_RVALID(CFG_RVALID), .JTAG_EXCL(JTAG_EXCL),
	.JTAG_CFG_PRI(JTAG_CFG_PRI)
);

`default_nettype wire

// [test/jtag_ctl_model.sv]
// Behavioural test controller that clocks the port and shifts scans.
// Assumes one device on the chain; the clock rests high between scans.
`default_nettype none

module jtag_ctl_model (
	output var logic tck,
	output var logic tms,
	output var logic tdi,
	input  wire logic tdo
);
	timeunit 1ns;
	timeprecision 1ns;

	logic o;

	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b1;
	end

	task automatic tick(input logic m, input logic d);
		tck = 1'b0;
		tms = m;
		tdi = d;
		#80;
		o = tdo;
		tck = 1'b1;
		#80;
	endtask : tick

	task automatic ir(input logic [5:0] c, output logic [5:0] cap);
		tick(1'b1, 1'b1);
		tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
		tick(1'b0, 1'b1);
		for (int i = 0; i < 6; i++) begin
			tick(i == 5, c[i]);
			cap[i] = o;
		end
		tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
	endtask : ir

	task automatic dr(input logic [31:0] d, output logic [31:0] q);
		tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
		tick(1'b0, 1'b1);
		for (int i = 0; i < 32; i++) begin
			tick(i == 31, d[i]);
			q[i] = o;
		end
		tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
	endtask : dr

	task automatic reset5;
		repeat (5) tick(1'b1, 1'b1);
		tick(1'b0, 1'b1);
	endtask : reset5
endmodule : jtag_ctl_model

`default_nettype wire

// [test/jtag_tap_config_access_tb.sv]
// Self-checking bench for the test port and its configuration handshakes.
// Assumes the controller model drives TCK at 160 ns and MCLK runs at 10 ns.
`default_nettype none

module jtag_tap_config_access_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        mclk, rst_n, ce, tck, tms, tdi, tdo_o, tdo_oe;
	logic        cfg_wvalid, cfg_rreq, cfg_rvalid, jtag_excl, jtag_cfg_pri, other_cfg_en;
	logic [2:0]  mode_pins;
	logic [7:0]  bsr_pi, bsr_po;
	logic [31:0] cfg_wdata, cfg_rdata, q;
	logic [5:0]  cap;
	tri1         tdo_w;
	int          errors, n_compared, i;

	assign tdo_w = tdo_oe ? tdo_o : 1'bz;

	jtag_tap_config_access jtag_tap_config_access_inst (
		.MCLK(mclk), .RST_N(rst_n), .CE(ce), .TCK(tck), .TMS(tms), .TDI(tdi),
		.TDO_O(tdo_o), .TDO_OE(tdo_oe), .MODE_PINS(mode_pins), .BSR_PI(bsr_pi),
		.BSR_PO(bsr_po), .CFG_WDATA(cfg_wdata), .CFG_WVALID(cfg_wvalid),
		.CFG_RREQ(cfg_rreq), .CFG_RVALID(cfg_rvalid), .CFG_RDATA(cfg_rdata),
		.JTAG_EXCL(jtag_excl), .JTAG_CFG_PRI(jtag_cfg_pri), .OTHER_CFG_EN(other_cfg_en)
	);
	jtag_ctl_model jtag_ctl_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_w));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic summarize;
		$display("compared %0d, wrong %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step

	task automatic bound;
		if (i >= 1000) begin
			errors++;
			summarize();
		end
	endtask : bound

	task automatic t_ident;
		check(tdo_w, 1'b1);
		check(tdo_oe, 1'b0);
		#3;
		jtag_ctl_model_inst.tick(1'b0, 1'b1);
		jtag_ctl_model_inst.dr(32'h0, q);
		check(q, jtag_pkg::ID_DEFAULT);
		jtag_ctl_model_inst.ir(jtag_pkg::INS_IDCODE, cap);
		check(cap, jtag_pkg::IR_CAPTURE);
		jtag_ctl_model_inst.dr(32'h0, q);
		check(q, jtag_pkg::ID_DEFAULT);
		$display("ident done");
	endtask : t_ident

	task automatic t_reset5;
		jtag_ctl_model_inst.ir(jtag_pkg::INS_BYPASS, cap);
		jtag_ctl_model_inst.tick(1'b1, 1'b1);
		jtag_ctl_model_inst.tick(1'b0, 1'b1);
		jtag_ctl_model_inst.tick(1'b0, 1'b1);
		jtag_ctl_model_inst.reset5();
		jtag_ctl_model_inst.dr(32'h0, q);
		check(q, jtag_pkg::ID_DEFAULT);
		$display("reset done");
	endtask : t_reset5

	task automatic t_bypass;
		logic [5:0] codes [2] = '{jtag_pkg::INS_BYPASS, 6'h2a};
		foreach (codes[k]) begin
			jtag_ctl_model_inst.ir(codes[k], cap);
			jtag_ctl_model_inst.dr(32'h9c3a51e7, q);
			check(q, 32'h9c3a51e7 << 1);
		end
		$display("bypass done");
	endtask : t_bypass

	task automatic t_boundary;
		bsr_pi = 8'h5a;
		jtag_ctl_model_inst.ir(jtag_pkg::INS_SAMPLE, cap);
		jtag_ctl_model_inst.dr(32'hc3a50000, q);
		check(q[7:0], 8'h5a);
		check(q[31:8], 24'ha50000);
		check(bsr_po, 8'h00);
		jtag_ctl_model_inst.ir(jtag_pkg::INS_EXTEST, cap);
		jtag_ctl_model_inst.dr(32'h96000000, q);
		check(bsr_po, 8'h96);
		$display("boundary done");
	endtask : t_boundary

	task automatic t_cfg_write;
		jtag_ctl_model_inst.ir(jtag_pkg::INS_CFG_IN, cap);
		step(10);
		check(jtag_cfg_pri, 1'b1);
		check(jtag_excl, 1'b0);
		fork
			jtag_ctl_model_inst.dr(32'h6b1e0f93, q);
			for (i = 0; i < 1000 && cfg_wvalid !== 1'b1; i++) step(1);
		join
		bound();
		check(cfg_wdata, 32'h6b1e0f93);
		$display("config write done");
	endtask : t_cfg_write

	task automatic t_cfg_read;
		jtag_ctl_model_inst.ir(jtag_pkg::INS_CFG_OUT, cap);
		for (i = 0; i < 1000 && cfg_rreq !== 1'b1; i++) step(1);
		bound();
		step(10);
		check(other_cfg_en, 1'b1);
		check(cfg_rreq, 1'b1);
		cfg_rvalid = 1'b1;
		cfg_rdata = 32'hd20c7e45;
		step(1);
		cfg_rvalid = 1'b0;
		cfg_rdata = ~cfg_rdata;
		check(cfg_rreq, 1'b0);
		repeat (6) jtag_ctl_model_inst.tick(1'b0, 1'b1);
		jtag_ctl_model_inst.dr(32'h0, q);
		check(q, 32'hd20c7e45);
		$display("config read done");
	endtask : t_cfg_read

	task automatic t_mode;
		step(1);
		mode_pins = jtag_pkg::MODE_JTAG;
		step(10);
		check(jtag_excl, 1'b1);
		check(jtag_cfg_pri, 1'b1);
		ce = 1'b0;
		mode_pins = 3'h2;
		step(10);
		check(jtag_excl, 1'b1);
		ce = 1'b1;
		step(10);
		check(jtag_excl, 1'b0);
		check(other_cfg_en, 1'b1);
		$display("mode done");
	endtask : t_mode

	initial begin
		errors = 0;
		n_compared = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		mode_pins = 3'h2;
		bsr_pi = 8'h00;
		cfg_rvalid = 1'b0;
		cfg_rdata = 32'h0;
		repeat (20) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		step(2);
		t_ident();
		t_reset5();
		t_bypass();
		t_boundary();
		t_cfg_write();
		t_cfg_read();
		t_mode();
		summarize();
	end
endmodule : jtag_tap_config_access_tb

`default_nettype wire
